// ==== rtl/pmc_pkg.sv ====
// Function
// - a 4-bit count steps up by one per counting edge, 15 wraps to 0.
// - the count changes only on the rising edge, async clear aside.
// - priority is async clear, sync clear, load, count, then hold.
// - async variant: a low clear zeroes the count at once.
// - sync variant: a low clear zeroes the count at the next edge.
// - with no clear and load low, the edge copies preset into count.
// - with no clear and load high, count steps if both enables high.
// - with no clear and load high, an enable low holds the count.
// - terminal count is trickle enable and all count bits one.
// - sync clear, load and count enables matter only at the rising edge.
//
// package of constants for the presettable modulo-16 counter.
// assumes one clock; shared by the core and the bus-facing top.

package pmc_pkg;

    // ****************************************************************
    // counter shape and modes
    // ****************************************************************
    localparam int CNT_WIDTH = 4;
    localparam logic [3:0] CNT_MAX = 4'hF;

    typedef enum logic [3:0] {
        PMC_HOLD = 4'b0001,
        PMC_COUNT = 4'b0010,
        PMC_LOAD = 4'b0100,
        PMC_CLEAR = 4'b1000
    } pmc_mode_t;

    // ****************************************************************
    // register map, byte addresses
    // ****************************************************************
    localparam logic [7:0] CTRL_OFF = 8'h00;
    localparam logic [7:0] PRESET_OFF = 8'h04;
    localparam logic [7:0] STATUS_OFF = 8'h08;
    localparam int ADDR_DEC_W = 8;

    // control: write-one command bits, read as zero
    localparam int CTRL_LOAD_BIT = 0;
    localparam int CTRL_CLEAR_BIT = 1;
    // status fields
    localparam int STAT_CNT_LSB = 0;
    localparam int STAT_TC_BIT = 4;
    localparam int STAT_ASYNC_BIT = 5;
    localparam logic [3:0] PRESET_RESET = 4'h0;

    // ****************************************************************
    // AHB-Lite encodings
    // ****************************************************************
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'h0;

    function automatic logic pmc_hit(input logic [7:0] addr,
                                     input logic [7:0] off);
        return addr == off;
    endfunction

endpackage

// ==== rtl/pmc_counter_core.sv ====
// counter core: four count flip-flop stages, mode select and terminal count.
// assumes control inputs other than the clear pin are synchronous to clk_in.
`timescale 1ns/1ps

module pmc_counter_core
    import pmc_pkg::*;
#(
    parameter int CNT_W = CNT_WIDTH,
    parameter bit ASYNC_CLEAR = 1'b1
) (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic clear_n_in,
    input wire logic sw_clear_in,
    input wire logic load_enable_n_in,
    input wire logic [CNT_W-1:0] preset_data_in,
    input wire logic count_enable_par_in,
    input wire logic count_enable_trickle_in,
    output logic [CNT_W-1:0] count_out,
    output logic terminal_count_out,
    output pmc_mode_t mode_out
);

    logic [CNT_W-1:0] count_ff;
    logic [CNT_W-1:0] nxt_count;
    wire logic pin_sync_clear;
    wire logic clear_req;
    wire logic count_req;
    pmc_mode_t mode;

    // ****************************************************************
    // mode select
    // ****************************************************************
    // the pin clears at the edge only in the synchronous variant
    assign pin_sync_clear = !ASYNC_CLEAR && !clear_n_in;
    assign clear_req = reset_in || pin_sync_clear || sw_clear_in;
    assign count_req = count_enable_par_in && count_enable_trickle_in;
    assign mode = clear_req ? PMC_CLEAR :
                  !load_enable_n_in ? PMC_LOAD :
                  count_req ? PMC_COUNT : PMC_HOLD;

    always_comb begin
        case (mode)
            PMC_CLEAR: nxt_count = '0;
            PMC_LOAD: nxt_count = preset_data_in;
            PMC_COUNT: nxt_count = CNT_W'(count_ff + 1'b1);
            default: nxt_count = count_ff;
        endcase
    end

    // ****************************************************************
    // state flip-flops
    // ****************************************************************
    generate
        if (ASYNC_CLEAR) begin : g_async
            always_ff @(posedge clk_in or negedge clear_n_in) begin
                if (!clear_n_in) begin
                    count_ff <= '0;
                end else begin
                    count_ff <= nxt_count;
                end
            end
        end else begin : g_sync
            always_ff @(posedge clk_in) begin
                count_ff <= nxt_count;
            end
        end
    endgenerate

    // decoded from flops, so it may glitch between edges
    assign terminal_count_out =
        count_enable_trickle_in && (&count_ff);
    assign count_out = count_ff;
    assign mode_out = mode;

endmodule

// ==== rtl/pmc_counter_top.sv ====
// top of the presettable modulo-16 counter with an AHB-Lite register port.
// assumes a single AHB-Lite master and inputs synchronous to sys_clk_in;
// the clear pin is asynchronous in one build variant.
//
// The register addresses and the AHB-Lite register port were chosen for this implementation.
`timescale 1ns/1ps

module pmc_counter_top
    import pmc_pkg::*;
#(
    parameter bit ASYNC_CLEAR = 1'b1
) (
    input wire logic sys_clk_in,
    input wire logic reset_in,
    // counter pins
    input wire logic clear_n_in,
    input wire logic load_enable_n_in,
    input wire logic [CNT_WIDTH-1:0] preset_data_in,
    input wire logic count_enable_par_in,
    input wire logic count_enable_trickle_in,
    output logic [CNT_WIDTH-1:0] count_out,
    output logic terminal_count_out,
    // AHB-Lite slave
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out
);

    // ****************************************************************
    // declarations
    // ****************************************************************
    logic [ADDR_DEC_W-1:0] addr_ff;
    logic wr_ff;
    logic [CNT_WIDTH-1:0] preset_ff;
    logic [31:0] hrdata_ff;
    logic [31:0] nxt_hrdata;
    wire logic addr_phase;
    wire logic rd_start;
    wire logic wr_ctrl;
    wire logic wr_preset;
    wire logic sw_load;
    wire logic sw_clear;
    wire logic eff_load_n;
    wire logic [CNT_WIDTH-1:0] eff_data;
    wire logic [CNT_WIDTH-1:0] cnt;
    wire logic tc;
    pmc_mode_t mode;
    wire logic [ADDR_DEC_W-1:0] req_addr;

    // ****************************************************************
    // AHB-Lite address and data phase
    // ****************************************************************
    // zero wait states: every transfer completes in its data phase
    assign addr_phase = hsel_in && hready_in &&
                        (htrans_in == HTRANS_NONSEQ);
    assign req_addr = haddr_in[ADDR_DEC_W-1:0];
    assign rd_start = addr_phase && !hwrite_in;

    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            wr_ff <= 1'b0;
            addr_ff <= '0;
        end else begin
            wr_ff <= addr_phase && hwrite_in;
            addr_ff <= addr_phase ? req_addr : addr_ff;
        end
    end

    assign wr_ctrl = wr_ff && pmc_hit(addr_ff, CTRL_OFF);
    assign wr_preset = wr_ff && pmc_hit(addr_ff, PRESET_OFF);

    // commands act on the edge that ends the write data phase
    assign sw_load = wr_ctrl && hwdata_in[CTRL_LOAD_BIT];
    assign sw_clear = wr_ctrl && hwdata_in[CTRL_CLEAR_BIT];

    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            preset_ff <= PRESET_RESET;
        end else if (wr_preset) begin
            preset_ff <= hwdata_in[CNT_WIDTH-1:0];
        end
    end

    // ****************************************************************
    // read mux, sampled at the address phase
    // ****************************************************************
    // status reflects the count as it stood at the address-phase edge
    always_comb begin
        nxt_hrdata = '0;
        if (pmc_hit(req_addr, PRESET_OFF)) begin
            nxt_hrdata[CNT_WIDTH-1:0] = preset_ff;
        end else if (pmc_hit(req_addr, STATUS_OFF)) begin
            nxt_hrdata[STAT_CNT_LSB +: CNT_WIDTH] = cnt;
            nxt_hrdata[STAT_TC_BIT] = tc;
            nxt_hrdata[STAT_ASYNC_BIT] = ASYNC_CLEAR;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            hrdata_ff <= '0;
        end else if (rd_start) begin
            hrdata_ff <= nxt_hrdata;
        end
    end

    assign hrdata_out = hrdata_ff;
    assign hreadyout_out = 1'b1;
    assign hresp_out = HRESP_OKAY;

    // ****************************************************************
    // pin and software merge
    // ****************************************************************
    // a software load borrows the load path; the pin load still wins
    // the data when both arrive together, software wins otherwise
    assign eff_load_n = load_enable_n_in && !sw_load;
    assign eff_data = load_enable_n_in ? preset_ff : preset_data_in;

    pmc_counter_core #(
        .CNT_W(CNT_WIDTH),
        .ASYNC_CLEAR(ASYNC_CLEAR)
    ) u_core (
        .clk_in(sys_clk_in),
        .reset_in(reset_in),
        .clear_n_in(clear_n_in),
        .sw_clear_in(sw_clear),
        .load_enable_n_in(eff_load_n),
        .preset_data_in(eff_data),
        .count_enable_par_in(count_enable_par_in),
        .count_enable_trickle_in(count_enable_trickle_in),
        .count_out(cnt),
        .terminal_count_out(tc),
        .mode_out(mode)
    );

    assign count_out = cnt;
    // terminal count is combinational; chain it into enables only
    assign terminal_count_out = tc;

    // ****************************************************************
    // assertions
    // ****************************************************************
    wire logic clr_any;
    wire logic cnt_go;
    wire logic hold_go;
    wire logic load_go;

    assign clr_any = !clear_n_in || sw_clear;
    assign cnt_go = !clr_any && eff_load_n &&
                    count_enable_par_in && count_enable_trickle_in;
    assign hold_go = !clr_any && eff_load_n &&
                     !(count_enable_par_in && count_enable_trickle_in);
    assign load_go = !clr_any && !eff_load_n;

    property p_wrap;
        @(posedge sys_clk_in) disable iff (reset_in || !clear_n_in)
        (cnt_go && cnt == CNT_MAX) |=> (cnt == '0);
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("count did not wrap from fifteen to zero");

    property p_step;
        @(posedge sys_clk_in) disable iff (reset_in || !clear_n_in)
        cnt_go |=> (cnt == CNT_WIDTH'($past(cnt) + 1'b1));
    endproperty
    a_step: assert property (p_step)
        else $error("count did not step by one with both enables");

    property p_hold;
        @(posedge sys_clk_in) disable iff (reset_in || !clear_n_in)
        hold_go |=> $stable(cnt);
    endproperty
    a_hold: assert property (p_hold)
        else $error("count moved with an enable low");

    property p_load;
        @(posedge sys_clk_in) disable iff (reset_in || !clear_n_in)
        load_go |=> (cnt == $past(eff_data));
    endproperty
    a_load: assert property (p_load)
        else $error("preset data not loaded bit for bit");

    property p_pin_bits;
        @(posedge sys_clk_in) disable iff (reset_in || !clear_n_in)
        (load_go && !load_enable_n_in) |=>
            (cnt[0] == $past(preset_data_in[0])) &&
            (cnt[CNT_WIDTH-1] == $past(preset_data_in[CNT_WIDTH-1]));
    endproperty
    a_pin_bits: assert property (p_pin_bits)
        else $error("preset bit landed on the wrong count bit");

    property p_prio;
        @(posedge sys_clk_in) disable iff (reset_in)
        (sw_clear && !load_enable_n_in && count_enable_par_in)
            |=> (cnt == '0);
    endproperty
    a_prio: assert property (p_prio)
        else $error("clear lost to load or count");

    property p_tc;
        @(posedge sys_clk_in) disable iff (reset_in)
        tc == (count_enable_trickle_in && cnt == CNT_MAX);
    endproperty
    a_tc: assert property (p_tc)
        else $error("terminal count wrong for state and trickle");

    property p_only_edge;
        @(posedge sys_clk_in) disable iff (reset_in)
        // a reset edge shows up as a change one edge later
        (!$stable(cnt) && $past(clear_n_in) && clear_n_in &&
            !$past(reset_in)) |-> $past(!hold_go);
    endproperty
    a_only_edge: assert property (p_only_edge)
        else $error("count changed without a load, count or clear");

    generate
        if (ASYNC_CLEAR) begin : g_a_async
            property p_aclr;
                @(posedge sys_clk_in) disable iff (reset_in)
                !clear_n_in |-> (cnt == '0);
            endproperty
            a_aclr: assert property (p_aclr)
                else $error("count not held at zero by clear pin");
        end else begin : g_a_sync
            property p_sclr;
                @(posedge sys_clk_in) disable iff (reset_in)
                !clear_n_in |=> (cnt == '0);
            endproperty
            a_sclr: assert property (p_sclr)
                else $error("clear pin did not zero the count");

            property p_sclr_late;
                @(posedge sys_clk_in) disable iff (reset_in)
                ($fell(clear_n_in) && cnt != '0 && $past(hold_go))
                    |-> (cnt != '0);
            endproperty
            a_sclr_late: assert property (p_sclr_late)
                else $error("synchronous clear acted before the edge");
        end
    endgenerate

    property p_ahb_okay;
        @(posedge sys_clk_in) disable iff (reset_in)
        rd_start |=> (hreadyout_out && hresp_out == HRESP_OKAY);
    endproperty
    a_ahb_okay: assert property (p_ahb_okay)
        else $error("slave did not complete with OKAY");

    property p_status_read;
        @(posedge sys_clk_in) disable iff (reset_in)
        (rd_start && pmc_hit(req_addr, STATUS_OFF)) |=>
            (hrdata_out[STAT_CNT_LSB +: CNT_WIDTH] == $past(cnt));
    endproperty
    a_status_read: assert property (p_status_read)
        else $error("status read does not show the count");

    property p_mode_clear;
        @(posedge sys_clk_in) disable iff (reset_in)
        sw_clear |-> (mode == PMC_CLEAR);
    endproperty
    a_mode_clear: assert property (p_mode_clear)
        else $error("software clear did not select the clear mode");

    property p_mode_load;
        @(posedge sys_clk_in) disable iff (reset_in)
        load_go |-> (mode == PMC_LOAD);
    endproperty
    a_mode_load: assert property (p_mode_load)
        else $error("load did not win over count");

    property p_mode_hold;
        @(posedge sys_clk_in) disable iff (reset_in)
        hold_go |-> (mode == PMC_HOLD);
    endproperty
    a_mode_hold: assert property (p_mode_hold)
        else $error("an enable low did not select the hold mode");

    property p_sw_clear;
        @(posedge sys_clk_in) disable iff (reset_in)
        sw_clear |=> (cnt == '0);
    endproperty
    a_sw_clear: assert property (p_sw_clear)
        else $error("software clear did not zero the count");

    // software load takes the register unless the pin loads too
    property p_sw_load;
        @(posedge sys_clk_in) disable iff (reset_in || !clear_n_in)
        (sw_load && load_enable_n_in && !sw_clear) |=>
            (cnt == $past(preset_ff));
    endproperty
    a_sw_load: assert property (p_sw_load)
        else $error("software load did not take the preset register");

    property p_preset_wr;
        @(posedge sys_clk_in) disable iff (reset_in)
        wr_preset |=> (preset_ff == $past(hwdata_in[CNT_WIDTH-1:0]));
    endproperty
    a_preset_wr: assert property (p_preset_wr)
        else $error("preset register missed its write");

    property p_rd_stands;
        @(posedge sys_clk_in) disable iff (reset_in)
        !rd_start |=> $stable(hrdata_out);
    endproperty
    a_rd_stands: assert property (p_rd_stands)
        else $error("read data moved outside a read address phase");

    // ****************************************************************
    // cover points
    // ****************************************************************
    c_wrap: cover property (@(posedge sys_clk_in) disable iff (reset_in)
        cnt_go && cnt == CNT_MAX ##1 cnt == '0);
    c_pin_load: cover property (@(posedge sys_clk_in)
        disable iff (reset_in) load_go && !load_enable_n_in);
    c_sw_load: cover property (@(posedge sys_clk_in)
        disable iff (reset_in) sw_load && load_enable_n_in);
    c_tc: cover property (@(posedge sys_clk_in) disable iff (reset_in)
        tc ##1 cnt == '0);
    c_clear: cover property (@(posedge sys_clk_in) disable iff (reset_in)
        cnt != '0 ##1 !clear_n_in);

endmodule

// ==== tb/pmc_cascade_model.sv ====
// next more significant counter stage, standing beyond terminal count.
// assumes the same clock and reset as the counter under test.
`timescale 1ns/1ps

module pmc_cascade_model (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic count_enable_par_in,
    input wire logic terminal_count_in,
    output logic [3:0] upper_out
);
    logic [3:0] upper_ff;
    logic [3:0] nxt_upper;

    // terminal count only enables, it never clocks or clears: it may glitch
    assign nxt_upper = (count_enable_par_in && terminal_count_in) ?
                       upper_ff + 4'h1 : upper_ff;
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            upper_ff <= 4'h0;
        end else begin
            upper_ff <= nxt_upper;
        end
    end
    assign upper_out = upper_ff;
endmodule

// ==== tb/pmc_counter_top_tb.sv ====
// self-checking bench for the presettable counter, both clear variants.
// assumes zero wait-state bus answers and a cascaded upper stage model.
`timescale 1ns/1ps

module pmc_counter_top_tb;
    import pmc_pkg::*;
    logic sys_clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic clear_n = 1'b1, load_n = 1'b1, par = 1'b0, trk = 1'b0;
    logic [3:0] preset = 4'h0;
    logic hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [3:0] cnt_a, cnt_s, upper, base, exp;
    logic tc_a, tc_s, rdy, resp;
    logic [31:0] rdat, rd;
    int num_errors = 0, n_compared = 0, cycles = 0;

    always #2 sys_clk_in = ~sys_clk_in;

    pmc_counter_top #(.ASYNC_CLEAR(1'b1)) i_dut (.sys_clk_in(sys_clk_in),
        .reset_in(reset_in), .clear_n_in(clear_n), .load_enable_n_in(load_n),
        .preset_data_in(preset), .count_enable_par_in(par),
        .count_enable_trickle_in(trk), .count_out(cnt_a),
        .terminal_count_out(tc_a), .hsel_in(hsel), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize),
        .hwdata_in(hwdata), .hready_in(rdy), .hrdata_out(rdat),
        .hreadyout_out(rdy), .hresp_out(resp));
    pmc_counter_top #(.ASYNC_CLEAR(1'b0)) i_dut_sync (.sys_clk_in(sys_clk_in),
        .reset_in(reset_in), .clear_n_in(clear_n), .load_enable_n_in(load_n),
        .preset_data_in(preset), .count_enable_par_in(par),
        .count_enable_trickle_in(trk), .count_out(cnt_s),
        .terminal_count_out(tc_s), .hsel_in(hsel), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize),
        .hwdata_in(hwdata), .hready_in(1'b1), .hrdata_out(),
        .hreadyout_out(), .hresp_out());
    pmc_cascade_model i_upper (.clk_in(sys_clk_in), .reset_in(reset_in),
        .count_enable_par_in(par), .terminal_count_in(tc_a),
        .upper_out(upper));

    // ****************************************************************
    // shared tasks
    // ****************************************************************
    task test_done;
        $display("compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task check(input logic [31:0] seen, input logic [31:0] want);
        n_compared++;
        if (seen !== want) begin
            num_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time,
                     seen, want);
        end
    endtask

    // the master waits for hready at each phase, assuming no fixed latency
    task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
             output logic [31:0] rv);
        @(posedge sys_clk_in);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr <= {24'h0, a};
        hwrite <= wr;
        do @(posedge sys_clk_in); while (rdy !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge sys_clk_in); while (rdy !== 1'b1);
        rv = rdat;
        check({31'h0, resp}, {31'h0, HRESP_OKAY});
    endtask

    task step(input int n);
        repeat (n) @(posedge sys_clk_in);
        #1;
    endtask

    always @(posedge sys_clk_in) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            test_done;
        end
    end

    // ****************************************************************
    // tests
    // ****************************************************************
    initial begin
        step(3);
        reset_in <= 1'b0;
        check({28'h0, cnt_a}, 32'h0);
        $display("test reset done");
        // load has priority over count; bit n maps to bit n
        @(posedge sys_clk_in);
        {load_n, par, trk, preset} <= {3'b011, 4'h1};
        step(1);
        check({28'h0, cnt_a}, 32'h1);
        preset <= 4'hD;
        step(1);
        check({28'h0, cnt_a}, 32'hD);
        load_n <= 1'b1;
        exp = 4'hD;
        for (int i = 0; i < 4; i++) begin
            check({31'h0, tc_a}, {31'h0, exp == 4'hF});
            step(1);
            exp = exp + 4'h1;
            check({28'h0, cnt_a}, {28'h0, exp});
        end
        $display("test load and count done");
        // load_n pulses low between edges: nothing may be taken
        #0.5 load_n = 1'b0;
        #1 load_n = 1'b1;
        step(1);
        check({28'h0, cnt_a}, 32'h2);
        load_n <= 1'b0;
        preset <= 4'hF;
        step(1);
        {load_n, par} <= 2'b10;
        check({31'h0, tc_a}, 32'h1);
        check({31'h0, tc_s}, 32'h1);
        step(2);
        check({28'h0, cnt_a}, 32'hF);
        trk <= 1'b0;
        par <= 1'b1;
        step(1);
        check({31'h0, tc_a}, 32'h0);
        check({31'h0, tc_s}, 32'h0);
        check({28'h0, cnt_s}, 32'hF);
        $display("test hold and terminal count done");
        // clear beats load: async at once, sync at the edge
        load_n <= 1'b0;
        clear_n = 1'b0;
        #0.5;
        check({28'h0, cnt_a}, 32'h0);
        check({28'h0, cnt_s}, 32'hF);
        step(1);
        check({28'h0, cnt_s}, 32'h0);
        clear_n <= 1'b1;
        load_n <= 1'b1;
        $display("test clear variants done");
        // register port: preset, commands, status and a hole
        ahb(1'b1, PRESET_OFF, 32'hFFFF_FFF5, rd);
        ahb(1'b0, PRESET_OFF, 32'h0, rd);
        check(rd, 32'h5);
        ahb(1'b1, CTRL_OFF, 32'h1, rd);
        #1 check({28'h0, cnt_a}, 32'h5);
        ahb(1'b0, CTRL_OFF, 32'h0, rd);
        check(rd, 32'h0);
        ahb(1'b0, STATUS_OFF, 32'h0, rd);
        check(rd, 32'h25);
        // clear must beat a pin load that stands with an enable high
        load_n <= 1'b0;
        ahb(1'b1, CTRL_OFF, 32'h2, rd);
        #1 check({28'h0, cnt_a}, 32'h0);
        check({28'h0, cnt_s}, 32'h0);
        load_n <= 1'b1;
        ahb(1'b0, 8'h0C, 32'h0, rd);
        check(rd, 32'h0);
        $display("test register port done");
        // two wraps carry twice into the cascaded stage
        base = upper;
        {trk, par} <= 2'b11;
        step(32);
        {trk, par} <= 2'b00;
        check({28'h0, cnt_a}, 32'h0);
        check({28'h0, upper}, {28'h0, base + 4'h2});
        $display("test cascade done");
        test_done;
    end
endmodule
